// ===== common/ric_pkg.sv
// Constants for the RTC interrupt routing and alarm match block
// How it works
// - Watchdog timeout always sets its flag; drives interrupt only when enabled.
// - Alarm match always sets its flag; drives interrupt only when enabled.
// - Power fail always sets its flag; drives interrupt only when enabled.
// - Polarity bit 1 drives output high; 0 gives open-drain active low.
// - Clear mask bit compares that alarm field; set mask bit ignores it.
package ric_pkg;
   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam logic [16:0] ADDR_ALARM_HOURS = 17'h1_fff4;
   localparam logic [16:0] ADDR_ALARM_DATE = 17'h1_fff5;
   localparam logic [16:0] ADDR_INT_CTRL = 17'h1_fff6;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CTRL_WD_EN_BIT = 7;
   localparam int CTRL_AL_EN_BIT = 6;
   localparam int CTRL_PWR_EN_BIT = 5;
   localparam int CTRL_POL_BIT = 3;
   localparam int CTRL_PULSE_BIT = 2;
   localparam logic [7:0] CTRL_WR_MASK = 8'hec;
   localparam int ALARM_MASK_BIT = 7;
   localparam logic [7:0] ALARM_WR_MASK = 8'hbf;
   localparam logic [5:0] ALARM_VAL_MASK = 6'h3f;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] ALARM_RESET = 8'h00;
   localparam logic [7:0] RD_ZERO = 8'h00;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_FREQ_HZ = 25_000_000;
   localparam int PULSE_TIME_MS = 200;
   localparam int PULSE_CYCLES =
      (CLK_FREQ_HZ / 1000) * PULSE_TIME_MS;

   // Interrupt output states
   typedef enum logic [1:0] {
      RIC_INT_IDLE = 2'b01,
      RIC_INT_ACTIVE = 2'b10
   } ric_int_state_type;
endpackage

// ===== design/ric_pulse_timer.sv
// Down counter that holds busy for a fixed number of cycles after start
`timescale 1ns/1ns
module ric_pulse_timer #(
   parameter int CYCLES = ric_pkg::PULSE_CYCLES
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_start,
   input wire logic i_cancel,
   output logic o_busy
);
   localparam int CNT_W = $clog2(CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CYCLES);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic busy_next;

   // Load on start, count down, stop at zero
   always_comb begin
      cnt_next = cnt_reg;
      if (i_start) begin
         cnt_next = CNT_LOAD;
      end else if (i_cancel) begin
         cnt_next = CNT_ZERO;
      end else if (cnt_reg != CNT_ZERO) begin
         cnt_next = cnt_reg - CNT_ONE;
      end
      busy_next = (cnt_next != CNT_ZERO);
   end

   // Counter and busy flop
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_reg <= '0;
         o_busy <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         o_busy <= busy_next;
      end
   end
endmodule

// ===== design/ric_top.sv
// Interrupt routing, output drive and hours/date alarm match of the RTC
`timescale 1ns/1ns
module ric_top #(
   parameter int PULSE_CYCLES = ric_pkg::PULSE_CYCLES
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [16:0] i_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rd_data,
   input wire logic i_watchdog_timeout,
   input wire logic i_power_fail_pin,
   input wire logic [7:0] i_cur_hours,
   input wire logic [7:0] i_cur_date,
   input wire logic i_flags_read,
   output logic o_watchdog_timeout_flag,
   output logic o_alarm_match_flag,
   output logic o_power_fail_flag,
   output logic o_alarm_match,
   output logic o_int_out,
   output logic o_int_oe
);
   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [7:0] alarm_hours_reg;
   logic [7:0] alarm_hours_next;
   logic [7:0] alarm_date_reg;
   logic [7:0] alarm_date_next;
   logic [7:0] rd_data_next;

   logic [1:0] pwr_sync_reg;
   logic [1:0] pwr_sync_next;
   logic pwr_level_reg;
   logic pwr_level_next;
   logic pwr_event;

   logic match_now;
   logic match_reg;
   logic match_next;
   logic alarm_event;
   logic field_hours_ok;
   logic field_date_ok;

   logic wd_flag_next;
   logic al_flag_next;
   logic pwr_flag_next;

   logic wd_irq_en;
   logic al_irq_en;
   logic pwr_irq_en;
   logic pol_high;
   logic pulse_mode;
   logic fire;

   ric_pkg::ric_int_state_type int_state_reg;
   ric_pkg::ric_int_state_type int_state_next;
   logic pulse_busy;
   logic pulse_start;
   logic pulse_cancel;
   logic int_active;
   logic int_out_next;
   logic int_oe_next;

   // ****************************************************************
   // Register bus
   // ****************************************************************

   // Writes store the defined bits; reserved bits stay zero
   always_comb begin
      ctrl_next = ctrl_reg;
      alarm_hours_next = alarm_hours_reg;
      alarm_date_next = alarm_date_reg;
      if (i_wr) begin
         unique case (i_addr)
            ric_pkg::ADDR_INT_CTRL: begin
               ctrl_next = i_wr_data & ric_pkg::CTRL_WR_MASK;
            end
            ric_pkg::ADDR_ALARM_HOURS: begin
               alarm_hours_next = i_wr_data & ric_pkg::ALARM_WR_MASK;
            end
            ric_pkg::ADDR_ALARM_DATE: begin
               alarm_date_next = i_wr_data & ric_pkg::ALARM_WR_MASK;
            end
            default: begin
               ctrl_next = ctrl_reg;
            end
         endcase
      end
   end

   // Read data for the cycle after the strobe, zero otherwise
   always_comb begin
      rd_data_next = ric_pkg::RD_ZERO;
      if (i_rd) begin
         unique case (i_addr)
            ric_pkg::ADDR_INT_CTRL: begin
               rd_data_next = ctrl_reg;
            end
            ric_pkg::ADDR_ALARM_HOURS: begin
               rd_data_next = alarm_hours_reg;
            end
            ric_pkg::ADDR_ALARM_DATE: begin
               rd_data_next = alarm_date_reg;
            end
            default: begin
               rd_data_next = ric_pkg::RD_ZERO;
            end
         endcase
      end
   end

   // Register file and read data flops
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_reg <= ric_pkg::CTRL_RESET;
         alarm_hours_reg <= ric_pkg::ALARM_RESET;
         alarm_date_reg <= ric_pkg::ALARM_RESET;
         o_rd_data <= ric_pkg::RD_ZERO;
      end else begin
         ctrl_reg <= ctrl_next;
         alarm_hours_reg <= alarm_hours_next;
         alarm_date_reg <= alarm_date_next;
         o_rd_data <= rd_data_next;
      end
   end

   // Control field taps
   assign wd_irq_en = ctrl_reg[ric_pkg::CTRL_WD_EN_BIT];
   assign al_irq_en = ctrl_reg[ric_pkg::CTRL_AL_EN_BIT];
   assign pwr_irq_en = ctrl_reg[ric_pkg::CTRL_PWR_EN_BIT];
   assign pol_high = ctrl_reg[ric_pkg::CTRL_POL_BIT];
   assign pulse_mode = ctrl_reg[ric_pkg::CTRL_PULSE_BIT];

   // ****************************************************************
   // Event sources
   // ****************************************************************

   // Power fail pin: two-flop synchroniser, then edge detect
   always_comb begin
      pwr_sync_next = {pwr_sync_reg[0], i_power_fail_pin};
      pwr_level_next = pwr_sync_reg[1];
   end

   assign pwr_event = pwr_sync_reg[1] & ~pwr_level_reg;

   // Alarm comparator, a set mask bit ignores that field
   always_comb begin
      field_hours_ok = alarm_hours_reg[ric_pkg::ALARM_MASK_BIT] |
         ((i_cur_hours[5:0] & ric_pkg::ALARM_VAL_MASK) ==
          (alarm_hours_reg[5:0] & ric_pkg::ALARM_VAL_MASK));
      field_date_ok = alarm_date_reg[ric_pkg::ALARM_MASK_BIT] |
         ((i_cur_date[5:0] & ric_pkg::ALARM_VAL_MASK) ==
          (alarm_date_reg[5:0] & ric_pkg::ALARM_VAL_MASK));
      match_now = field_hours_ok & field_date_ok;
      match_next = match_now;
   end

   // One event as the match condition becomes true
   assign alarm_event = match_now & ~match_reg;

   // Synchroniser and comparator history flops
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         pwr_sync_reg <= 2'b00;
         pwr_level_reg <= 1'b0;
         match_reg <= 1'b0;
      end else begin
         pwr_sync_reg <= pwr_sync_next;
         pwr_level_reg <= pwr_level_next;
         match_reg <= match_next;
      end
   end

   // ****************************************************************
   // Flags
   // ****************************************************************

   // Events set flags whatever the enables; set wins over clear
   always_comb begin
      wd_flag_next = o_watchdog_timeout_flag & ~i_flags_read;
      al_flag_next = o_alarm_match_flag & ~i_flags_read;
      pwr_flag_next = o_power_fail_flag & ~i_flags_read;
      if (i_watchdog_timeout) begin
         wd_flag_next = 1'b1;
      end
      if (alarm_event) begin
         al_flag_next = 1'b1;
      end
      if (pwr_event) begin
         pwr_flag_next = 1'b1;
      end
   end

   // Flag flops and match status
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_watchdog_timeout_flag <= 1'b0;
         o_alarm_match_flag <= 1'b0;
         o_power_fail_flag <= 1'b0;
         o_alarm_match <= 1'b0;
      end else begin
         o_watchdog_timeout_flag <= wd_flag_next;
         o_alarm_match_flag <= al_flag_next;
         o_power_fail_flag <= pwr_flag_next;
         o_alarm_match <= match_now;
      end
   end

   // ****************************************************************
   // Interrupt output
   // ****************************************************************

   // Only enabled sources reach the interrupt
   assign fire = (i_watchdog_timeout & wd_irq_en) |
                 (alarm_event & al_irq_en) |
                 (pwr_event & pwr_irq_en);

   // Pulse mode starts the timer; level mode cancels any pulse
   assign pulse_start = fire & pulse_mode;
   assign pulse_cancel = ~pulse_mode;

   ric_pulse_timer #(
      .CYCLES(PULSE_CYCLES)
   ) ric_pulse_timer_i (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_start(pulse_start),
      .i_cancel(pulse_cancel),
      .o_busy(pulse_busy)
   );

   // Level mode holds until flags read; a new fire wins over the read
   always_comb begin
      int_state_next = int_state_reg;
      unique case (int_state_reg)
         ric_pkg::RIC_INT_IDLE: begin
            if (fire & ~pulse_mode) begin
               int_state_next = ric_pkg::RIC_INT_ACTIVE;
            end
         end
         ric_pkg::RIC_INT_ACTIVE: begin
            if (pulse_mode) begin
               int_state_next = ric_pkg::RIC_INT_IDLE;
            end else if (i_flags_read & ~fire) begin
               int_state_next = ric_pkg::RIC_INT_IDLE;
            end
         end
         default: begin
            int_state_next = ric_pkg::RIC_INT_IDLE;
         end
      endcase
   end

   // Drive shape from polarity select
   always_comb begin
      int_active = pulse_mode ? pulse_busy :
         (int_state_reg == ric_pkg::RIC_INT_ACTIVE);
      if (pol_high) begin
         int_out_next = int_active;
         int_oe_next = 1'b1;
      end else begin
         int_out_next = 1'b0;
         int_oe_next = int_active;
      end
   end

   // Interrupt state and pin flops
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         int_state_reg <= ric_pkg::RIC_INT_IDLE;
         o_int_out <= 1'b0;
         o_int_oe <= 1'b0;
      end else begin
         int_state_reg <= int_state_next;
         o_int_out <= int_out_next;
         o_int_oe <= int_oe_next;
      end
   end
endmodule

// ===== tb/ric_host.sv
// Host side of the interrupt line with its pull-up
`timescale 1ns/1ns
module ric_host (
   input wire logic i_int_out,
   input wire logic i_int_oe,
   output logic o_pin
);
   // Released line floats up to the pull-up level
   assign o_pin = i_int_oe ? i_int_out : 1'b1;
endmodule

// ===== tb/ric_top_chk.sv
// Port checker for the interrupt routing block
`timescale 1ns/1ns
module ric_top_chk (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_rd,
   input wire logic [7:0] o_rd_data,
   input wire logic i_watchdog_timeout,
   input wire logic i_power_fail_pin,
   input wire logic i_flags_read,
   input wire logic o_watchdog_timeout_flag,
   input wire logic o_alarm_match_flag,
   input wire logic o_power_fail_flag,
   input wire logic o_alarm_match,
   input wire logic o_int_out,
   input wire logic o_int_oe
);
   default clocking @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);
   // ***********************************************
   // Sequences
   // ***********************************************
   sequence pwr_rise;
      $rose(i_power_fail_pin) ##1 i_power_fail_pin;
   endsequence
   // ***********************************************
   // Assertions
   // ***********************************************
   a_wd_flag_set: assert property (
      i_watchdog_timeout |=> o_watchdog_timeout_flag)
      else $error("watchdog flag not set");
   a_wd_flag_clear: assert property (
      i_flags_read && !i_watchdog_timeout |=> !o_watchdog_timeout_flag)
      else $error("watchdog flag not cleared");
   a_alarm_flag_set: assert property (
      $rose(o_alarm_match) |-> ##[0:2] o_alarm_match_flag)
      else $error("alarm flag not set");
   a_pwr_flag_set: assert property (
      pwr_rise |-> ##[1:4] o_power_fail_flag)
      else $error("power fail flag not set");
   a_pin_drive_kind: assert property (
      o_int_out |-> o_int_oe)
      else $error("pin high while released");
   a_rd_data_idle: assert property (
      !i_rd |=> o_rd_data == 8'h00)
      else $error("read data without strobe");
endmodule
bind ric_top ric_top_chk ric_top_chk_i (.i_core_clk, .i_rst, .i_rd,
   .o_rd_data, .i_watchdog_timeout, .i_power_fail_pin, .i_flags_read,
   .o_watchdog_timeout_flag, .o_alarm_match_flag, .o_power_fail_flag,
   .o_alarm_match, .o_int_out, .o_int_oe);

// ===== tb/ric_top_tb.sv
// Self-checking bench for the interrupt routing block
`timescale 1ns/1ns
module ric_top_tb;
   localparam int PC = 20;
   logic clk = 0, rst = 1, wr = 0, rd = 0, wd = 0, pwr = 0, fr = 0;
   logic [16:0] addr = 0;
   logic [7:0] wdat = 0, hrs = 8'h3f, dat = 8'h00, rdat;
   logic wtf, amf, pwf, am, io, ioe, pin;
   int fail_count = 0, tests_run = 0, cyc = 0, n;
   initial forever #20 clk = ~clk;
   ric_top #(.PULSE_CYCLES(PC)) ric_top_i (.i_core_clk(clk),
      .i_rst(rst), .i_addr(addr), .i_wr_data(wdat), .i_wr(wr),
      .i_rd(rd), .o_rd_data(rdat), .i_watchdog_timeout(wd),
      .i_power_fail_pin(pwr), .i_cur_hours(hrs), .i_cur_date(dat),
      .i_flags_read(fr), .o_watchdog_timeout_flag(wtf),
      .o_alarm_match_flag(amf), .o_power_fail_flag(pwf),
      .o_alarm_match(am), .o_int_out(io), .o_int_oe(ioe));
   ric_host ric_host_i (.i_int_out(io), .i_int_oe(ioe), .o_pin(pin));
   // ***********************************************
   // Shared tasks
   // ***********************************************
   task chk(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task wr_reg(input logic [16:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdat <= d;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
   endtask
   task rd_reg(input logic [16:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1 chk(rdat, e);
   endtask
   task wd_ev;
      @(posedge clk);
      wd <= 1;
      @(posedge clk);
      wd <= 0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task clr(input logic [7:0] c);
      wr_reg(ric_pkg::ADDR_INT_CTRL, c);
      @(posedge clk);
      fr <= 1;
      @(posedge clk);
      fr <= 0;
      repeat (3) @(posedge clk);
   endtask
   task test_done;
      $display("tests=%0d fails=%0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ***********************************************
   // Scenarios
   // ***********************************************
   task t_regs;
      rd_reg(ric_pkg::ADDR_INT_CTRL, 8'h00);
      wr_reg(ric_pkg::ADDR_INT_CTRL, 8'hff);
      rd_reg(ric_pkg::ADDR_INT_CTRL, 8'hec);
      wr_reg(ric_pkg::ADDR_ALARM_HOURS, 8'hff);
      rd_reg(ric_pkg::ADDR_ALARM_HOURS, 8'hbf);
      wr_reg(17'h1_fff7, 8'h55);
      rd_reg(17'h1_fff7, 8'h00);
      $display("t_regs done");
   endtask
   task t_wd;
      clr(8'h88);
      wd_ev;
      chk(pin, 1);
      repeat (5) @(posedge clk);
      #1 chk(pin, 1);
      chk(wtf, 1);
      clr(8'h08);
      chk(pin, 0);
      wd_ev;
      chk(pin, 0);
      chk(wtf, 1);
      clr(8'h80);
      wd_ev;
      chk(ioe, 1);
      chk(pin, 0);
      clr(8'h80);
      chk(pin, 1);
      $display("t_wd done");
   endtask
   task t_pulse;
      clr(8'h8c);
      wd_ev;
      chk(pin, 1);
      // Pin already high for the two cycles before the loop
      n = 2;
      repeat (40) begin
         @(posedge clk);
         #1 if (pin) n++;
      end
      chk(8'(n), 8'(PC));
      chk(wtf, 1);
      $display("t_pulse done");
   endtask
   task t_alarm;
      clr(8'h48);
      wr_reg(ric_pkg::ADDR_ALARM_HOURS, 8'h12);
      wr_reg(ric_pkg::ADDR_ALARM_DATE, 8'h85);
      hrs <= 8'h11;
      clr(8'h48);
      chk(amf, 0);
      chk(am, 0);
      hrs <= 8'h12;
      repeat (4) @(posedge clk);
      #1 chk(amf, 1);
      chk(pin, 1);
      chk(am, 1);
      $display("t_alarm done");
   endtask
   task t_pwr;
      clr(8'h28);
      pwr <= 1;
      repeat (6) @(posedge clk);
      #1 chk(pwf, 1);
      chk(pin, 1);
      @(posedge clk);
      pwr <= 0;
      $display("t_pwr done");
   endtask
   // Cycle ceiling against a hang
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         $display("[ERR] t=%0t cycles=%h limit=%h", $time, cyc, 5000);
         test_done;
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 0;
      t_regs;
      t_wd;
      t_pulse;
      t_alarm;
      t_pwr;
      test_done;
   end
endmodule
